// ---- gpm_defs.svh ----
// offsets, field codes and counts for the pin mux and debug share block
`ifndef GPM_DEFS_SVH
`define GPM_DEFS_SVH
`define GPM_NPIN 45
`define GPM_NPIN_A 32
`define GPM_NPIN_B 13
`define GPM_NAIO 16
`define GPM_NCFG 7
`define GPM_A_CTRL 16'h6f80
`define GPM_A_QSEL_LO 16'h6f82
`define GPM_A_QSEL_HI 16'h6f84
`define GPM_A_MUX_LO 16'h6f86
`define GPM_A_MUX_HI 16'h6f88
`define GPM_A_DIR 16'h6f8a
`define GPM_A_PUD 16'h6f8c
`define GPM_B_CTRL 16'h6f90
`define GPM_B_QSEL 16'h6f92
`define GPM_B_MUX 16'h6f96
`define GPM_B_DIR 16'h6f9a
`define GPM_B_PUD 16'h6f9c
`define GPM_AIO_MUX 16'h6fb6
`define GPM_AIO_DIR 16'h6fba
`define GPM_A_DAT 16'h6fc0
`define GPM_A_SET 16'h6fc2
`define GPM_A_CLR 16'h6fc4
`define GPM_A_TGL 16'h6fc6
`define GPM_B_DAT 16'h6fc8
`define GPM_B_SET 16'h6fca
`define GPM_B_CLR 16'h6fcc
`define GPM_B_TGL 16'h6fce
`define GPM_AIO_DAT 16'h6fd8
`define GPM_AIO_SET 16'h6fda
`define GPM_AIO_CLR 16'h6fdc
`define GPM_AIO_TGL 16'h6fde
`define GPM_IRQ1_SEL 16'h6fe0
`define GPM_IRQ3_SEL 16'h6fe2
`define GPM_LPM_SEL 16'h6fe8
`define GPM_RST_WORD 32'h0
`define GPM_FN_GPIO 2'h0
`define GPM_QS_SYNC 2'h0
`define GPM_QS_3 2'h1
`define GPM_QS_6 2'h2
`define GPM_QS_ASYNC 2'h3
`define GPM_PIN_TDI 35
`define GPM_PIN_TMS 36
`define GPM_PIN_TDO 37
`define GPM_PIN_TCK 38
`endif

// ---- gpm_gpio_mux.sv ----
// pin mux, qualification, port registers and debug pin sharing
`include "gpm_defs.svh"
// Notes on behaviour
// [R1] each pin carries software bit I/O or one of three peripheral signals
// [R2] 45 pins: port A is pins 0 to 31, port B pins 32 to 44
// [R3] registers accept 32-bit and 16-bit accesses
// [R4] each port has a sampling period control for its qualification
// [R5] port A qualifier select in two registers, port B in one
// [R6] port A function select in two registers, port B in one
// [R7] per-pin direction control for each port
// [R8] setting a pull-up disable bit turns that pin's pull-up off
// [R9] each port has data, set, clear and toggle registers on one latch
// [R10] sixteen analog-capable pins have mux, direction, data, set, clear and toggle registers, with no control, qualifier or pull-up registers
// [R11] three interrupt selectors each pick one port A pin
// [R12] low-power selection marks which port A pins take part
// [R13] selector and control registers change only while the gate is open
// [R14] debug port uses five pins, four shared with general pins
// [R15] test-reset level picks debug or general use of shared pins
// [R16] general function of shared pins is unavailable in debug mode
// [R17] outside party should clock from elsewhere while debugging
// [R18] function and qualifier selects take effect two cycles after write
// [R19] two-bit function field, 00 is plain I/O and the reset state
// [R20] software must not pick a function code with no peripheral
// [R21] a one in set, clear or toggle acts on that latch bit
// [R22] data reads give qualified levels, writes load latches of outputs
module gpm_gpio_mux (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input gpm_pkg::gpm_bus_req_type bus,
  output logic [31:0] bus_rdata,
  output logic bus_rvalid,
  input wire logic write_protect_gate,
  // general pins
  input wire logic [`GPM_NPIN-1:0] pin_in,
  output logic [`GPM_NPIN-1:0] pin_out,
  output logic [`GPM_NPIN-1:0] pin_oe,
  output logic [`GPM_NPIN-1:0] pin_pullup_en,
  // peripheral side, three functions per pin
  input wire logic [`GPM_NPIN-1:0][2:0] periph_out,
  input wire logic [`GPM_NPIN-1:0][2:0] periph_oe,
  output logic [`GPM_NPIN-1:0][2:0] periph_in,
  // analog-capable pins
  input wire logic [`GPM_NAIO-1:0] aio_in,
  output logic [`GPM_NAIO-1:0] aio_out,
  output logic [`GPM_NAIO-1:0] aio_oe,
  output logic [`GPM_NAIO-1:0] aio_analog_sel,
  // interrupt and low-power
  output logic [2:0] external_irq_level,
  output logic low_power_state_wake,
  // debug port sharing
  input wire logic dbg_test_reset,
  input wire logic dbg_tdo,
  input wire logic dbg_tdo_oe,
  output logic dbg_tck,
  output logic dbg_tdi,
  output logic dbg_tms
);
  import gpm_pkg::*;

  localparam logic [`GPM_NCFG-1:0][15:0] CFG_BASE = {`GPM_AIO_MUX, `GPM_B_MUX,
    `GPM_A_MUX_HI, `GPM_A_MUX_LO, `GPM_B_QSEL, `GPM_A_QSEL_HI, `GPM_A_QSEL_LO};
  localparam logic [12:0] DBG_MASK_B = 13'h0078;

  gpm_state_type r;
  gpm_state_type next_r;
  logic [89:0] qsel_all;
  logic [89:0] mux_all;
  logic [`GPM_NPIN-1:0] q_eff;
  logic [`GPM_NPIN-1:0] dir_all;
  logic st_a;
  logic st_b;

  // only the delayed copies steer the pins; the written copy is what reads see
  assign qsel_all = {r.cfg_eff[2][25:0], r.cfg_eff[1], r.cfg_eff[0]}; // [R5] [R18]
  assign mux_all = {r.cfg_eff[5][25:0], r.cfg_eff[4], r.cfg_eff[3]}; // [R6] [R18]
  assign dir_all = {r.dir_b, r.dir_a}; // [R2] [R7]
  assign st_a = (r.cnt_a == 9'h0);
  assign st_b = (r.cnt_b == 9'h0);

  // async mode bypasses the qualifier entirely
  always_comb begin
    for (int p = 0; p < `GPM_NPIN; p++) begin
      q_eff[p] = (qsel_all[2*p+:2] == `GPM_QS_ASYNC) ? pin_in[p] : r.qual[p];
    end
  end

  // mask in the upper half, data in the lower half; odd-address 32-bit
  // accesses are treated as misaligned and ignored
  function automatic logic [63:0] wr(input logic [15:0] base);
    logic [31:0] m;
    logic [31:0] d;
    m = '0;
    d = '0;
    if (bus.sel && bus.we) begin
      if (bus.addr == base) begin
        m[15:0] = 16'hffff;
        d[15:0] = bus.wdata[15:0];
        if (bus.wide) begin
          m[31:16] = 16'hffff;
          d[31:16] = bus.wdata[31:16];
        end
      end else if (!bus.wide && bus.addr == 16'(base + 16'h1)) begin
        m[31:16] = 16'hffff;
        d[31:16] = bus.wdata[15:0];
      end
    end
    return {m, d};
  endfunction : wr

  function automatic logic [31:0] upd(input logic [31:0] old, input logic [63:0] md);
    return (old & ~md[63:32]) | (md[31:0] & md[63:32]);
  endfunction : upd

  function automatic logic [31:0] ones(input logic [63:0] md);
    return md[63:32] & md[31:0];
  endfunction : ones

  // set, clear, toggle and data write onto one latch word
  function automatic logic [31:0] latch_upd(input logic [31:0] old, input logic [31:0] dir,
                                            input logic [15:0] base);
    logic [31:0] v;
    logic [63:0] md;
    md = wr(base);
    v = upd(old, {md[63:32] & dir, md[31:0]}); // [R22]
    v = v | ones(wr(16'(base + 16'h2))); // [R21]
    v = v & ~ones(wr(16'(base + 16'h4))); // [R21]
    v = v ^ ones(wr(16'(base + 16'h6))); // [R21]
    return v;
  endfunction : latch_upd

  function automatic logic [31:0] rd_word(input logic [15:0] a);
    logic [31:0] w;
    w = `GPM_RST_WORD;
    for (int i = 0; i < `GPM_NCFG; i++) begin
      if (a == CFG_BASE[i]) w = r.cfg[i];
    end
    case (a)
      `GPM_A_CTRL: w = r.ctrl_a;
      `GPM_B_CTRL: w = r.ctrl_b;
      `GPM_A_DIR: w = r.dir_a;
      `GPM_A_PUD: w = r.pud_a;
      `GPM_B_DIR: w = {19'h0, r.dir_b};
      `GPM_B_PUD: w = {19'h0, r.pud_b};
      `GPM_AIO_DIR: w = {16'h0, r.aio_dir};
      `GPM_A_DAT: w = q_eff[31:0]; // [R22]
      `GPM_B_DAT: w = {19'h0, q_eff[44:32] & ~({13{dbg_test_reset}} & DBG_MASK_B)}; // [R16]
      `GPM_AIO_DAT: w = {16'h0, r.aio_qual};
      `GPM_IRQ1_SEL: w = {11'h0, r.xsel[1], 11'h0, r.xsel[0]};
      `GPM_IRQ3_SEL: w = {27'h0, r.xsel[2]};
      `GPM_LPM_SEL: w = r.lpm_sel;
      default: ;
    endcase
    return w;
  endfunction : rd_word

  always_comb begin
    logic [31:0] t;
    logic [31:0] rw;
    logic [63:0] md;
    logic [1:0] qs;
    logic st;
    logic [5:0] h;
    t = '0;
    rw = '0;
    md = '0;
    qs = '0;
    st = 1'b0;
    h = '0;
    next_r = r;
    next_r.rvalid = 1'b0;
    next_r.cfg_p1 = r.cfg; // [R18]
    next_r.cfg_eff = r.cfg_p1; // [R18]
    // sampling period: 0 samples every cycle, n samples every 2n cycles
    next_r.cnt_a = st_a ? ((r.ctrl_a[7:0] == 8'h0) ? 9'h0 : 9'({r.ctrl_a[7:0], 1'b0} - 9'h1))
                        : 9'(r.cnt_a - 9'h1); // [R4]
    next_r.cnt_b = st_b ? ((r.ctrl_b[7:0] == 8'h0) ? 9'h0 : 9'({r.ctrl_b[7:0], 1'b0} - 9'h1))
                        : 9'(r.cnt_b - 9'h1); // [R4]
    if (write_protect_gate) begin // [R13]
      next_r.ctrl_a = upd(r.ctrl_a, wr(`GPM_A_CTRL)); // [R4]
      next_r.ctrl_b = upd(r.ctrl_b, wr(`GPM_B_CTRL)); // [R4]
      for (int i = 0; i < `GPM_NCFG; i++) begin
        next_r.cfg[i] = upd(r.cfg[i], wr(CFG_BASE[i])); // [R5] [R6] [R10]
      end
      next_r.cfg[2][31:26] = 6'h0;
      next_r.cfg[5][31:26] = 6'h0;
      next_r.dir_a = upd(r.dir_a, wr(`GPM_A_DIR)); // [R7]
      next_r.pud_a = upd(r.pud_a, wr(`GPM_A_PUD)); // [R8]
      t = upd({19'h0, r.dir_b}, wr(`GPM_B_DIR));
      next_r.dir_b = t[12:0]; // [R7]
      t = upd({19'h0, r.pud_b}, wr(`GPM_B_PUD));
      next_r.pud_b = t[12:0]; // [R8]
      t = upd({16'h0, r.aio_dir}, wr(`GPM_AIO_DIR));
      next_r.aio_dir = t[15:0]; // [R10]
      md = wr(`GPM_IRQ1_SEL);
      if (md[32]) next_r.xsel[0] = md[4:0]; // [R11]
      if (md[48]) next_r.xsel[1] = md[20:16]; // [R11]
      md = wr(`GPM_IRQ3_SEL);
      if (md[32]) next_r.xsel[2] = md[4:0]; // [R11]
      next_r.lpm_sel = upd(r.lpm_sel, wr(`GPM_LPM_SEL)); // [R12]
    end
    next_r.lat_a = latch_upd(r.lat_a, r.dir_a, `GPM_A_DAT); // [R9]
    t = latch_upd({19'h0, r.lat_b}, {19'h0, r.dir_b}, `GPM_B_DAT);
    next_r.lat_b = t[12:0]; // [R9]
    t = latch_upd({16'h0, r.lat_aio}, {16'h0, r.aio_dir}, `GPM_AIO_DAT);
    next_r.lat_aio = t[15:0]; // [R10]
    next_r.aio_qual = aio_in;
    // qualifier: sync takes every cycle, 3 or 6 equal samples otherwise
    for (int p = 0; p < `GPM_NPIN; p++) begin
      qs = qsel_all[2*p+:2];
      st = (p < `GPM_NPIN_A) ? st_a : st_b;
      h = st ? {r.hist[p][4:0], pin_in[p]} : r.hist[p];
      next_r.hist[p] = h;
      case (qs)
        `GPM_QS_3: if (h[2:0] == 3'h7 || h[2:0] == 3'h0) next_r.qual[p] = h[0];
        `GPM_QS_6: if (h == 6'h3f || h == 6'h00) next_r.qual[p] = h[0];
        default: next_r.qual[p] = pin_in[p];
      endcase
    end
    if (bus.sel && !bus.we) begin // [R3]
      rw = rd_word({bus.addr[15:1], 1'b0});
      next_r.rvalid = 1'b1;
      if (bus.wide) next_r.rdata = bus.addr[0] ? `GPM_RST_WORD : rw;
      else next_r.rdata = {16'h0, bus.addr[0] ? rw[31:16] : rw[15:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r <= '0; // [R19]
    end else begin
      r <= next_r;
    end
  end

  // pin routing
  always_comb begin
    logic [1:0] fs;
    fs = '0;
    for (int p = 0; p < `GPM_NPIN; p++) begin
      fs = mux_all[2*p+:2];
      periph_in[p] = '0;
      if (fs == `GPM_FN_GPIO) begin // [R19]
        pin_out[p] = (p < `GPM_NPIN_A) ? r.lat_a[p % 32] : r.lat_b[(p - 32) % 13];
        pin_oe[p] = dir_all[p]; // [R7]
      end else begin // [R1]
        pin_out[p] = periph_out[p][fs - 2'h1];
        pin_oe[p] = periph_oe[p][fs - 2'h1];
        periph_in[p][fs - 2'h1] = q_eff[p];
      end
      if (dbg_test_reset && (p >= `GPM_PIN_TDI) && (p <= `GPM_PIN_TCK)) begin // [R14] [R15]
        periph_in[p] = '0; // [R16]
        pin_out[p] = (p == `GPM_PIN_TDO) ? dbg_tdo : 1'b0;
        pin_oe[p] = (p == `GPM_PIN_TDO) ? dbg_tdo_oe : 1'b0;
      end
    end
  end

  // debug inputs skip qualification, their timing belongs to the probe
  assign dbg_tck = dbg_test_reset & pin_in[`GPM_PIN_TCK]; // [R14] [R17]
  assign dbg_tdi = dbg_test_reset & pin_in[`GPM_PIN_TDI]; // [R14]
  assign dbg_tms = dbg_test_reset & pin_in[`GPM_PIN_TMS]; // [R14]
  assign pin_pullup_en = ~{r.pud_b, r.pud_a}; // [R8]

  always_comb begin
    for (int i = 0; i < `GPM_NAIO; i++) begin
      aio_analog_sel[i] = (r.cfg_eff[6][2*i+:2] != `GPM_FN_GPIO); // [R10]
    end
  end
  assign aio_out = r.lat_aio; // [R10]
  assign aio_oe = r.aio_dir & ~aio_analog_sel; // [R10]

  assign external_irq_level[0] = q_eff[r.xsel[0]]; // [R11]
  assign external_irq_level[1] = q_eff[r.xsel[1]]; // [R11]
  assign external_irq_level[2] = q_eff[r.xsel[2]]; // [R11]
  // a low level on any selected pin asks to leave the low-power state
  assign low_power_state_wake = |(r.lpm_sel & ~q_eff[31:0]); // [R12]
  assign bus_rdata = r.rdata;
  assign bus_rvalid = r.rvalid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_set_bits_high: assert property (bus.sel && bus.we && bus.wide && bus.addr == `GPM_A_SET
    |=> (r.lat_a & $past(bus.wdata)) == $past(bus.wdata)) else $error("set missed"); // [R21]
  a_clear_bits_low: assert property (bus.sel && bus.we && bus.wide && bus.addr == `GPM_A_CLR
    |=> (r.lat_a & $past(bus.wdata)) == 32'h0) else $error("clear missed"); // [R21]
  a_cfg_two_cycle: assert property ($changed(r.cfg[3])
    |-> ##2 r.cfg_eff[3] == $past(r.cfg[3], 2)) else $error("select delay wrong"); // [R18]
  a_gate_blocks_write: assert property (bus.sel && bus.we && !write_protect_gate
    |=> r.lpm_sel == $past(r.lpm_sel) && r.dir_a == $past(r.dir_a))
    else $error("protected write landed"); // [R13]
  a_dbg_pins_owned: assert property (dbg_test_reset |-> !pin_oe[`GPM_PIN_TCK] &&
    !pin_oe[`GPM_PIN_TDI] && pin_oe[`GPM_PIN_TDO] == dbg_tdo_oe)
    else $error("shared pin driven in debug"); // [R16]
  a_gpio_path: assert property (mux_all[1:0] == `GPM_FN_GPIO
    |-> pin_out[0] == r.lat_a[0] && pin_oe[0] == r.dir_a[0]) else $error("gpio path"); // [R19]
  a_read_data: assert property (bus.sel && !bus.we && bus.wide && bus.addr == `GPM_A_DAT
    |=> bus_rvalid && bus_rdata == $past(q_eff[31:0])) else $error("data read"); // [R22]
  a_half_write: assert property (bus.sel && bus.we && !bus.wide && write_protect_gate &&
    bus.addr == 16'h6f8b |=> r.dir_a[15:0] == $past(r.dir_a[15:0]) &&
    r.dir_a[31:16] == $past(bus.wdata[15:0])) else $error("half write"); // [R3]
  a_irq_route: assert property ($changed(r.xsel[0]) |->
    r.xsel[0] == $past(bus.wdata[4:0])) else $error("irq route"); // [R11]

  c_mux_write: cover property ($changed(r.cfg[3]) ##2 $changed(r.cfg_eff[3]));
  c_debug_mode: cover property ($rose(dbg_test_reset) ##1 dbg_tdo_oe);
  c_toggle: cover property (bus.sel && bus.we && bus.addr == `GPM_A_TGL);
endmodule : gpm_gpio_mux

// ---- gpm_pin_model.sv ----
// board pins seen from the pin mux block: drivers, pull-ups and floating lines
`include "gpm_defs.svh"
module gpm_pin_model (
  // clock
  input wire logic clk,
  // from the block
  input wire logic [`GPM_NPIN-1:0] pin_out,
  input wire logic [`GPM_NPIN-1:0] pin_oe,
  input wire logic [`GPM_NPIN-1:0] pin_pullup_en,
  // board drive set by the bench
  input wire logic [`GPM_NPIN-1:0] ext_level,
  input wire logic [`GPM_NPIN-1:0] ext_drive,
  // resolved pin levels
  output logic [`GPM_NPIN-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip = 1'b0;
  // a floating pin must not settle, or a missing pull-up would go unseen
  always @(posedge clk) flip <= ~flip;
  always_comb begin
    for (int i = 0; i < `GPM_NPIN; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drive[i] ? ext_level[i] :
                  pin_pullup_en[i] ? 1'b1 : flip;
    end
  end
endmodule : gpm_pin_model

// ---- gpm_pkg.sv ----
// types shared by the pin mux and debug share block
`include "gpm_defs.svh"
package gpm_pkg;
  typedef struct packed {
    logic sel;
    logic we;
    logic wide;
    logic [15:0] addr;
    logic [31:0] wdata;
  } gpm_bus_req_type;

  typedef struct packed {
    logic [`GPM_NCFG-1:0][31:0] cfg;
    logic [`GPM_NCFG-1:0][31:0] cfg_p1;
    logic [`GPM_NCFG-1:0][31:0] cfg_eff;
    logic [31:0] ctrl_a;
    logic [31:0] ctrl_b;
    logic [31:0] dir_a;
    logic [31:0] pud_a;
    logic [31:0] lpm_sel;
    logic [12:0] dir_b;
    logic [12:0] pud_b;
    logic [15:0] aio_dir;
    logic [31:0] lat_a;
    logic [12:0] lat_b;
    logic [15:0] lat_aio;
    logic [2:0][4:0] xsel;
    logic [8:0] cnt_a;
    logic [8:0] cnt_b;
    logic [`GPM_NPIN-1:0][5:0] hist;
    logic [`GPM_NPIN-1:0] qual;
    logic [15:0] aio_qual;
    logic [31:0] rdata;
    logic rvalid;
  } gpm_state_type;
endpackage : gpm_pkg

// ---- tb.sv ----
// self-checking bench for the pin mux and debug share block
`include "gpm_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import gpm_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  gpm_bus_req_type bus = '0;
  logic gate = 1'b0;
  logic [44:0] pin_in, pin_out, pin_oe, pull_en;
  logic [44:0] ext_lvl = '0;
  logic [44:0] ext_drv = '0;
  logic [44:0][2:0] p_out = '0;
  logic [44:0][2:0] p_oe = '1;
  logic [44:0][2:0] p_in;
  logic [15:0] aio_out, aio_oe;
  logic [15:0] aio_drv = 16'h00a5;
  logic [2:0] irq;
  logic wake, tck, tdi, tms;
  logic tst_rst = 1'b0;
  logic tdo = 1'b1;
  logic tdo_oe = 1'b1;
  logic [31:0] rdata, rd_v;
  logic rvalid;
  int fails = 0;
  int checked = 0;

  always #20 clk = ~clk;

  gpm_gpio_mux u_dut (.clk(clk), .sys_rst(sys_rst), .bus(bus), .bus_rdata(rdata),
    .bus_rvalid(rvalid), .write_protect_gate(gate), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_pullup_en(pull_en), .periph_out(p_out), .periph_oe(p_oe),
    .periph_in(p_in), .aio_in(aio_drv), .aio_out(aio_out), .aio_oe(aio_oe),
    .aio_analog_sel(), .external_irq_level(irq), .low_power_state_wake(wake),
    .dbg_test_reset(tst_rst), .dbg_tdo(tdo), .dbg_tdo_oe(tdo_oe), .dbg_tck(tck),
    .dbg_tdi(tdi), .dbg_tms(tms));

  gpm_pin_model u_pins (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pull_en), .ext_level(ext_lvl), .ext_drive(ext_drv), .pin_in(pin_in));

  task automatic test_done;
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // requests are raised after a falling edge and dropped after the taking edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic w = 1'b1);
    @(negedge clk);
    bus = '{1'b1, 1'b1, w, a, d};
    @(negedge clk);
    bus.sel = 1'b0;
  endtask : wr

  task automatic rchk(input string what, input logic [15:0] a, input logic [31:0] exp,
                      input logic w = 1'b1);
    @(negedge clk);
    bus = '{1'b1, 1'b0, w, a, 32'h0};
    @(negedge clk);
    bus.sel = 1'b0;
    chk("read strobe", 32'h1, 32'(rvalid));
    chk(what, exp, rdata);
  endtask : rchk

  initial begin
    #(40 * 3000);
    fails++;
    test_done();
  end

  initial begin
    repeat (12) @(posedge clk);
    @(negedge clk) sys_rst = 1'b0;
    rchk("dir a", `GPM_A_DIR, '0);
    rchk("mux a", `GPM_A_MUX_LO, '0);
    chk("pullups", 32'hffff_ffff, pull_en[31:0]);
    $display("test reset done");
    wr(`GPM_A_DIR, 32'hffff_ffff);
    rchk("dir locked", `GPM_A_DIR, '0);
    gate = 1'b1;
    wr(`GPM_A_DIR, 32'hffff_ffff);
    rchk("dir open", `GPM_A_DIR, 32'hffff_ffff);
    chk("oe a", 32'hffff_ffff, pin_oe[31:0]);
    wr(`GPM_A_PUD, 32'h0000_000f);
    wr(`GPM_A_PUD + 16'h1, 32'h0000_8000, 1'b0);
    rchk("pud word", `GPM_A_PUD, 32'h8000_000f);
    rchk("pud half", `GPM_A_PUD + 16'h1, 32'h0000_8000, 1'b0);
    chk("pullup off", 32'h7fff_fff0, pull_en[31:0]);
    rchk("hole", 16'h6fa0, '0);
    $display("test registers done");
    wr(`GPM_A_SET, 32'h0000_00ff);
    wr(`GPM_A_CLR, 32'h0000_000f);
    wr(`GPM_A_TGL, 32'h0000_0033);
    chk("latch a", 32'h0000_00c3, pin_out[31:0]);
    rchk("set reads", `GPM_A_SET, '0);
    rchk("data a", `GPM_A_DAT, 32'h0000_00c3);
    wr(`GPM_A_DIR, 32'h0000_00ff);
    wr(`GPM_A_DAT, 32'hffff_ffff);
    wr(`GPM_A_DIR, 32'hffff_ffff);
    chk("data load", 32'h0000_00ff, pin_out[31:0]);
    $display("test latch done");
    // pin 0 latch is 1 and function slot 2 drives 1: codes alternate the level
    p_out[0] = 3'b010;
    for (int k = 1; k < 5; k++) begin
      wr(`GPM_A_MUX_LO, 32'(k % 4));
      @(negedge clk);
      chk("mux held", 32'(k[0]), 32'(pin_out[0]));
      @(negedge clk);
      chk("mux route", 32'(k[0] ? 1'b0 : 1'b1), 32'(pin_out[0]));
    end
    $display("test mux done");
    wr(`GPM_IRQ1_SEL, 32'h0000_0005, 1'b0);
    wr(`GPM_IRQ3_SEL, 32'h0000_0009, 1'b0);
    wr(`GPM_LPM_SEL, 32'h0000_0300);
    repeat (2) @(negedge clk);
    chk("irq levels", 32'h3, 32'(irq));
    chk("wake low", 32'h1, 32'(wake));
    wr(`GPM_LPM_SEL, 32'h0000_0001);
    @(negedge clk);
    chk("wake high", 32'h0, 32'(wake));
    $display("test select done");
    wr(`GPM_B_DIR, 32'h0000_1fff);
    ext_drv[38] = 1'b1;
    ext_lvl[38] = 1'b1;
    ext_drv[35] = 1'b1;
    ext_lvl[35] = 1'b1;
    tst_rst = 1'b1;
    repeat (2) @(negedge clk);
    chk("debug oe", 32'h4, 32'(pin_oe[38:35]));
    chk("debug tdo", 32'h1, 32'(pin_out[37]));
    chk("debug tck", 32'h1, 32'(tck));
    chk("debug tdi", 32'h1, 32'(tdi));
    chk("debug tms", 32'h1, 32'(tms));
    rchk("data b", `GPM_B_DAT, '0);
    tst_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("gpio oe", 32'hf, 32'(pin_oe[38:35]));
    chk("tck idle", 32'h0, 32'(tck));
    $display("test debug done");
    wr(`GPM_AIO_DIR, 32'h0000_ffff);
    wr(`GPM_AIO_SET, 32'h0000_0003);
    chk("aio out", 32'h3, 32'(aio_out));
    chk("aio oe", 32'hffff, 32'(aio_oe));
    rchk("aio data", `GPM_AIO_DAT, 32'h0000_00a5);
    $display("test analog done");
    test_done();
  end
endmodule : tb
